// *** design/rxbe_cfg.svh ***
// Purpose: Constants for the receive self-test, elasticity and output block
// Assumes: Included by the package users after rxbe_pkg
// Notes:   Offsets of the APB register file, control bits, buffer figures and status codes
`ifndef RXBE_CFG_SVH
`define RXBE_CFG_SVH
`define RXBE_OFS_CTRL       12'h000
`define RXBE_OFS_STAT       12'h004
`define RXBE_OFS_CNT        12'h008
`define RXBE_CTRL_RST       8'h00
`define RXBE_CTRL_SELFTEST  0
`define RXBE_CTRL_DECUSE    1
`define RXBE_CTRL_REFCLK    2
`define RXBE_CTRL_FRAMSEL   3
`define RXBE_CTRL_FRAMEN    4
`define RXBE_CTRL_FMODE     5
`define RXBE_CTRL_HALFRATE  7
`define RXBE_EB_DEPTH       10
`define RXBE_EB_MID         4'h5
`define RXBE_ERR_LIMIT      6'h10
`define RXBE_LFSR_SEED      9'h1ff
`define RXBE_K285_RAW       10'h17c
`define RXBE_K285_DEC       8'hbc
`define RXBE_START_CHAR     8'h00
`define RXBE_ST_DATA        3'h0
`define RXBE_ST_SPECIAL     3'h1
`define RXBE_ST_LOOP_A      3'h2
`define RXBE_ST_LOOP_B      3'h4
`define RXBE_ST_WAIT        3'h7
`define RXBE_ST_ERR         3'h6
`define RXBE_ST_MATCH       3'h0
`endif

// *** design/rxbe_pkg.sv ***
// Purpose: Types for the receive self-test, elasticity and output block
// Assumes: Nothing
// Notes:   Buffer entry is 8 data bits plus 3 status bits
package rxbe_pkg;
    typedef enum logic [1:0] {BS_IDLE, BS_WAIT, BS_RUN} rxbe_bist_t;
    typedef struct packed {
        logic [2:0] st;
        logic [7:0] data;
    } rxbe_ent_t;
    typedef struct packed {
        logic       half;
        logic [1:0] fmode;
        logic       fram_en;
        logic       fram_sel;
        logic       ref_mode;
        logic       dec_use;
        logic       sel;
    } rxbe_ctrl_t;
endpackage : rxbe_pkg

// *** design/rxbe_top.sv ***
// Purpose: Receive back end: self-test checker, elasticity buffer, output register
// Assumes: Characters arrive framed; I_CLK is the selected output clock
// Notes:   Write side runs on I_CLK too; the write strobe marks character periods
`timescale 1ns/1ps
`default_nettype none
`include "rxbe_cfg.svh"
module rxbe_top
    import rxbe_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RESETN,
    input  wire logic        I_CHAR_VALID,
    input  wire logic [9:0]  I_RAW_CHAR,
    input  wire logic [7:0]  I_DEC_DATA,
    input  wire logic [2:0]  I_DEC_STATUS,
    input  wire logic        I_PLL_LOCKED,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic [7:0]       O_RX_DATA_BITS,
    output logic [2:0]       O_RX_STATUS_BITS,
    output logic             O_RX_CLK_PHASE
);
    typedef struct packed {
        rxbe_ctrl_t  ctrl;
        rxbe_bist_t  bst;
        logic        en_seen;
        logic [8:0]  lfsr;
        logic [5:0]  diff;
        logic [8:0]  pos;
        logic        loop_b;
        logic [3:0]  wp;
        logic [3:0]  rp;
        logic [3:0]  cnt;
        logic [7:0]  out_d;
        logic [2:0]  out_s;
        logic        phase;
        logic [15:0] err_cnt;
        logic [31:0] rdata;
    } st_t;

    st_t st_ff;
    st_t nxt_st;
    rxbe_ent_t mem_ff [`RXBE_EB_DEPTH];
    rxbe_ent_t wr_ent;
    rxbe_ent_t rd_ent;
    rxbe_ent_t src_ent;
    logic       wr_en;
    logic       apb_wr;
    logic       apb_rd;
    logic       fram_hit;
    logic       is_fram;
    logic [7:0] exp_char;
    logic       fram_in_buf;
    logic [3:0] rp_next;

    assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
    assign apb_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = 1'b0;
    assign O_PRDATA = st_ff.rdata;

    // Framing match on the selected character at the framed boundary
    always_comb
    begin
        if (st_ff.ctrl.fram_sel)
            fram_hit = (I_RAW_CHAR == `RXBE_K285_RAW) || (I_RAW_CHAR == ~`RXBE_K285_RAW);
        else
            fram_hit = (I_RAW_CHAR[7:0] == 8'(`RXBE_K285_RAW))
                    || (I_RAW_CHAR[7:0] == ~8'(`RXBE_K285_RAW));
    end

    assign is_fram  = I_DEC_STATUS == `RXBE_ST_SPECIAL && I_DEC_DATA == `RXBE_K285_DEC;
    assign exp_char = st_ff.lfsr[7:0];
    assign rp_next  = (st_ff.rp == 4'(`RXBE_EB_DEPTH - 1)) ? 4'h0 : st_ff.rp + 4'h1;

    always_comb
    begin
        fram_in_buf = 1'b0;
        for (int i = 0; i < `RXBE_EB_DEPTH; i++)
        begin
            // Occupied entries run from the read pointer for cnt places
            if (4'((i + `RXBE_EB_DEPTH - int'(st_ff.rp)) % `RXBE_EB_DEPTH) < st_ff.cnt
                && mem_ff[i].data == `RXBE_K285_DEC
                && mem_ff[i].st == `RXBE_ST_SPECIAL)
                fram_in_buf = 1'b1;
        end
    end

    // Source character: decoded or raw bypass mapping
    always_comb
    begin
        if (st_ff.ctrl.dec_use)
        begin
            src_ent.data = I_DEC_DATA;
            src_ent.st   = I_DEC_STATUS;
        end
        else
        begin
            src_ent.data = I_RAW_CHAR[9:2];
            src_ent.st   = {fram_hit, I_RAW_CHAR[0], I_RAW_CHAR[1]};
        end
    end

    always_comb
    begin
        nxt_st = st_ff;
        wr_en  = 1'b0;
        wr_ent = src_ent;
        rd_ent = mem_ff[st_ff.rp];
        if (apb_wr && I_PADDR == `RXBE_OFS_CTRL)
            nxt_st.ctrl = I_PWDATA[7:0];
        if (apb_rd)
        begin
            case (I_PADDR)
                `RXBE_OFS_CTRL: nxt_st.rdata = {24'h0, st_ff.ctrl};
                `RXBE_OFS_STAT: nxt_st.rdata = {20'h0, st_ff.cnt, st_ff.bst, st_ff.diff};
                `RXBE_OFS_CNT:  nxt_st.rdata = {16'h0, st_ff.err_cnt};
                default:        nxt_st.rdata = 32'h0;
            endcase
        end
        if (apb_wr && I_PADDR == `RXBE_OFS_CNT)
            nxt_st.err_cnt = 16'h0;
        if (st_ff.ctrl.half)
            nxt_st.phase = ~st_ff.phase;
        else
            nxt_st.phase = 1'b1;
        // Self-test checker
        if (!st_ff.ctrl.sel)
        begin
            nxt_st.bst     = BS_IDLE;
            nxt_st.en_seen = 1'b0;
        end
        else if (!I_PLL_LOCKED)
        begin
            nxt_st.bst  = BS_WAIT;
            nxt_st.lfsr = {1'b0, `RXBE_START_CHAR};
        end
        else if (I_CHAR_VALID)
        begin
            case (st_ff.bst)
                BS_IDLE:
                begin
                    nxt_st.en_seen = 1'b1;
                    nxt_st.lfsr = {1'b0, `RXBE_START_CHAR};
                    nxt_st.bst  = BS_WAIT;
                end
                BS_WAIT:
                begin
                    if (src_ent.data == `RXBE_START_CHAR)
                    begin
                        nxt_st.bst  = BS_RUN;
                        nxt_st.lfsr = `RXBE_LFSR_SEED;
                        nxt_st.pos  = 9'h1;
                        nxt_st.diff = 6'h0;
                    end
                end
                BS_RUN:
                begin
                    nxt_st.lfsr = {st_ff.lfsr[7:0], st_ff.lfsr[8] ^ st_ff.lfsr[4]};
                    nxt_st.pos  = st_ff.pos + 9'h1;
                    // Coded violations are part of the loop, so only data is compared
                    if (src_ent.data != exp_char)
                    begin
                        nxt_st.err_cnt = st_ff.err_cnt + 16'h1;
                        nxt_st.diff = st_ff.diff + 6'h1;
                        if (st_ff.diff + 6'h1 > `RXBE_ERR_LIMIT)
                        begin
                            nxt_st.bst  = BS_WAIT;
                            nxt_st.lfsr = {1'b0, `RXBE_START_CHAR};
                        end
                    end
                    else if (st_ff.diff != 6'h0)
                        nxt_st.diff = st_ff.diff - 6'h1;
                    if (st_ff.pos == 9'h1fe)
                    begin
                        nxt_st.pos    = 9'h0;
                        nxt_st.loop_b = ~st_ff.loop_b;
                    end
                end
                default: nxt_st.bst = BS_IDLE;
            endcase
        end
        // Elasticity buffer in reference mode, else bypass
        if (st_ff.ctrl.ref_mode)
        begin
            if (I_CHAR_VALID)
            begin
                if (st_ff.cnt == 4'(`RXBE_EB_DEPTH) && is_fram && fram_in_buf)
                    wr_en = 1'b0;
                else if (st_ff.cnt < 4'(`RXBE_EB_DEPTH))
                    wr_en = 1'b1;
            end
            if (wr_en)
                nxt_st.wp = (st_ff.wp == 4'(`RXBE_EB_DEPTH - 1)) ? 4'h0 : st_ff.wp + 4'h1;
            if (st_ff.cnt != 4'h0)
            begin
                nxt_st.out_d = rd_ent.data;
                nxt_st.out_s = rd_ent.st;
                nxt_st.rp    = rp_next;
            end
            else if (fram_in_buf || st_ff.ctrl.dec_use)
            begin
                nxt_st.out_d = `RXBE_K285_DEC;
                nxt_st.out_s = `RXBE_ST_SPECIAL;
            end
            nxt_st.cnt = st_ff.cnt + 4'(wr_en) - 4'(st_ff.cnt != 4'h0);
        end
        else if (I_CHAR_VALID)
        begin
            nxt_st.out_d = src_ent.data;
            nxt_st.out_s = src_ent.st;
        end
        // Self-test status overrides the character status
        if (st_ff.ctrl.sel && st_ff.bst == BS_RUN && I_CHAR_VALID)
        begin
            if (st_ff.pos == 9'h1fe)
                nxt_st.out_s = st_ff.loop_b ? `RXBE_ST_LOOP_B : `RXBE_ST_LOOP_A;
            else if (src_ent.data != exp_char)
                nxt_st.out_s = `RXBE_ST_ERR;
            else
                nxt_st.out_s = `RXBE_ST_MATCH;
        end
        else if (st_ff.ctrl.sel && st_ff.bst == BS_WAIT)
            nxt_st.out_s = `RXBE_ST_WAIT;
    end

    generate
        for (genvar g = 0; g < `RXBE_EB_DEPTH; g++)
        begin : g_ent
            // Reset fills the entries with framing characters
            always_ff @(posedge I_CLK or negedge I_RESETN)
            begin
                if (!I_RESETN)
                    mem_ff[g] <= {`RXBE_ST_SPECIAL, `RXBE_K285_DEC};
                else if (wr_en && st_ff.wp == 4'(g))
                    mem_ff[g] <= wr_ent;
            end
        end
    endgenerate

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            st_ff      <= '0;
            st_ff.wp   <= `RXBE_EB_MID;
            st_ff.cnt  <= `RXBE_EB_MID;
            st_ff.ctrl <= `RXBE_CTRL_RST;
        end
        else
            st_ff <= nxt_st;
    end

    assign O_RX_DATA_BITS   = st_ff.out_d;
    assign O_RX_STATUS_BITS = st_ff.out_s;
    assign O_RX_CLK_PHASE   = st_ff.phase;

    property p_sel_off_idle;
        @(posedge I_CLK) disable iff (!I_RESETN)
        !st_ff.ctrl.sel |=> st_ff.bst == BS_IDLE;
    endproperty
    a_sel_off_idle: assert property (p_sel_off_idle) else $error("checker ran while disabled");

    property p_unlock;
        @(posedge I_CLK) disable iff (!I_RESETN)
        st_ff.ctrl.sel && !I_PLL_LOCKED |=> st_ff.bst == BS_WAIT;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock did not restart");

    property p_loop_end;
        @(posedge I_CLK) disable iff (!I_RESETN)
        st_ff.bst == BS_RUN && I_CHAR_VALID && st_ff.pos == 9'h1fe && st_ff.ctrl.sel
        |=> O_RX_STATUS_BITS inside {`RXBE_ST_LOOP_A, `RXBE_ST_LOOP_B};
    endproperty
    a_loop_end: assert property (p_loop_end) else $error("loop end status missing");

    property p_abort;
        @(posedge I_CLK) disable iff (!I_RESETN)
        st_ff.diff > `RXBE_ERR_LIMIT |-> st_ff.bst != BS_RUN;
    endproperty
    a_abort: assert property (p_abort) else $error("error excess not aborted");

    property p_cnt_max;
        @(posedge I_CLK) disable iff (!I_RESETN)
        st_ff.cnt <= 4'(`RXBE_EB_DEPTH);
    endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("buffer count overflow");

    property p_bypass;
        @(posedge I_CLK) disable iff (!I_RESETN)
        !st_ff.ctrl.ref_mode && !st_ff.ctrl.sel && I_CHAR_VALID && st_ff.ctrl.dec_use
        |=> O_RX_DATA_BITS == $past(I_DEC_DATA);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass data mismatch");

    property p_raw_map;
        @(posedge I_CLK) disable iff (!I_RESETN)
        !st_ff.ctrl.ref_mode && !st_ff.ctrl.sel && I_CHAR_VALID && !st_ff.ctrl.dec_use
        |=> O_RX_DATA_BITS == $past(I_RAW_CHAR[9:2]) && O_RX_STATUS_BITS[1] == $past(I_RAW_CHAR[0]);
    endproperty
    a_raw_map: assert property (p_raw_map) else $error("raw mapping wrong");

    property p_enable_start;
        @(posedge I_CLK) disable iff (!I_RESETN)
        st_ff.bst == BS_IDLE && st_ff.ctrl.sel && I_CHAR_VALID && I_PLL_LOCKED
        |=> st_ff.lfsr[7:0] == `RXBE_START_CHAR;
    endproperty
    a_enable_start: assert property (p_enable_start) else $error("start code not preset");

    sequence s_run_hit;
        st_ff.ctrl.sel && st_ff.bst == BS_RUN && I_CHAR_VALID && st_ff.pos != 9'h1fe
        && src_ent.data == exp_char;
    endsequence

    sequence s_run_miss;
        st_ff.ctrl.sel && st_ff.bst == BS_RUN && I_CHAR_VALID && st_ff.pos != 9'h1fe
        && src_ent.data != exp_char;
    endsequence

    property p_run_match;
        @(posedge I_CLK) disable iff (!I_RESETN)
        s_run_hit |=> O_RX_STATUS_BITS == `RXBE_ST_MATCH;
    endproperty
    a_run_match: assert property (p_run_match) else $error("match status missing");

    property p_run_error;
        @(posedge I_CLK) disable iff (!I_RESETN)
        s_run_miss |=> O_RX_STATUS_BITS == `RXBE_ST_ERR;
    endproperty
    a_run_error: assert property (p_run_error) else $error("error status missing");

    property p_rst_state;
        @(posedge I_CLK) disable iff (!I_RESETN)
        $rose(I_RESETN) |-> !st_ff.ctrl.sel && st_ff.cnt == `RXBE_EB_MID;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("reset state wrong");

    property p_fram_flag;
        @(posedge I_CLK) disable iff (!I_RESETN)
        !st_ff.ctrl.ref_mode && !st_ff.ctrl.dec_use && !st_ff.ctrl.sel && I_CHAR_VALID
        && st_ff.ctrl.fram_sel && I_RAW_CHAR != `RXBE_K285_RAW && I_RAW_CHAR != ~`RXBE_K285_RAW
        |=> !O_RX_STATUS_BITS[2];
    endproperty
    a_fram_flag: assert property (p_fram_flag) else $error("framing flag false");

    property p_bypass_hold;
        @(posedge I_CLK) disable iff (!I_RESETN)
        !st_ff.ctrl.ref_mode && !I_CHAR_VALID |=> $stable(O_RX_DATA_BITS);
    endproperty
    a_bypass_hold: assert property (p_bypass_hold) else $error("idle output moved");

    property p_wait_status;
        @(posedge I_CLK) disable iff (!I_RESETN)
        st_ff.ctrl.sel && st_ff.bst == BS_WAIT |=> O_RX_STATUS_BITS == `RXBE_ST_WAIT;
    endproperty
    a_wait_status: assert property (p_wait_status) else $error("wait status missing");
endmodule : rxbe_top
`default_nettype wire

// *** sim/rxbe_link_src.sv ***
// Purpose: Remote link source feeding framed characters to the receive back end
// Assumes: Tasks are entered just after a rising edge of i_clk
// Notes:   During a gap the lines carry the inverse of the last value; with gap 0 they hold it
`timescale 1ns/1ps
`default_nettype none
module rxbe_link_src (
    input  wire logic       i_clk,
    output logic            o_valid,
    output logic [9:0]      o_raw,
    output logic [7:0]      o_dec,
    output logic [2:0]      o_st
);
    initial
    begin
        o_valid = 1'b0;
        o_raw   = 10'h000;
        o_dec   = 8'h00;
        o_st    = 3'h0;
    end
    task automatic send(input logic [9:0] raw, input logic [7:0] dec,
                        input logic [2:0] st, input int gap);
        o_valid <= 1'b1;
        o_raw   <= raw;
        o_dec   <= dec;
        o_st    <= st;
        @(posedge i_clk);
        if (gap != 0)
        begin
            o_valid <= 1'b0;
            o_raw   <= ~raw;
            o_dec   <= ~dec;
            o_st    <= ~st;
            repeat (gap) @(posedge i_clk);
        end
    endtask : send
    // Framing characters give the buffer room to slip without touching data
    task automatic sync_word(input int n);
        for (int i = 0; i < n; i++)
            send(10'h17c, 8'hbc, 3'h1, 0);
    endtask : sync_word
endmodule : rxbe_link_src
`default_nettype wire

// *** sim/rxbe_top_tb.sv ***
// Purpose: Self-checking bench for the receive back end
// Assumes: Link source model drives the character inputs
// Notes:   Random values come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "rxbe_cfg.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module rxbe_top_tb;
    logic        clk;
    logic        resetn;
    logic        pll_ok;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        valid;
    logic [9:0]  raw;
    logic [7:0]  dec;
    logic [2:0]  st;
    logic [7:0]  rx_data;
    logic [2:0]  rx_st;
    logic        rx_ph;
    logic        collect;
    logic        p;
    logic [31:0] rd;
    logic [9:0]  r;
    logic [7:0]  d;
    logic [8:0]  lf;
    logic [7:0]  got_q[$];
    logic [7:0]  exp_q[$];
    logic [9:0]  fr[4] = '{10'h17c, 10'h283, 10'h27c, 10'h383};
    int          error_cnt;
    int          total_checks;
    int          seed;
    int          cycles;
    int          k;
    rxbe_top uut (.I_CLK(clk), .I_RESETN(resetn), .I_CHAR_VALID(valid), .I_RAW_CHAR(raw),
        .I_DEC_DATA(dec), .I_DEC_STATUS(st), .I_PLL_LOCKED(pll_ok), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_RX_DATA_BITS(rx_data), .O_RX_STATUS_BITS(rx_st), .O_RX_CLK_PHASE(rx_ph));
    rxbe_link_src src (.i_clk(clk), .o_valid(valid), .o_raw(raw), .o_dec(dec), .o_st(st));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            stop_test();
        end
        if (collect && !(rx_st === 3'h1 && rx_data === 8'hbc))
            got_q.push_back(rx_data);
    end
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= v;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        `CHK("pslverr", 1'b0, pslverr)
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (12) @(posedge clk);
        `CHK("out_rst", 12'h000, {rx_data, rx_st, rx_ph})
        resetn <= 1'b1;
        @(posedge clk);
        apb(1'b0, `RXBE_OFS_CTRL, 32'h0);
        `CHK("ctrl_sel", 1'b0, rd[`RXBE_CTRL_SELFTEST])
    endtask : do_reset
    function automatic logic [10:0] exp_byp(input logic [9:0] c, input logic fs);
        logic f;
        f = fs ? (c == 10'h17c || c == 10'h283) : (c[7:0] == 8'h7c || c[7:0] == 8'h83);
        return {c[9:2], f, c[0], c[1]};
    endfunction : exp_byp
    // Next state of the 9-bit pattern generator
    function automatic logic [8:0] lfsr_step(input logic [8:0] l);
        return {l[7:0], l[8] ^ l[4]};
    endfunction : lfsr_step
    initial
    begin
        seed = 88295;
        error_cnt = 0;
        total_checks = 0;
        cycles = 0;
        collect = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pll_ok = 1'b1;
        resetn = 1'b0;
        do_reset();
        apb(1'b0, `RXBE_OFS_STAT, 32'h0);
        `CHK("fill", `RXBE_EB_MID, rd[11:8])
        apb(1'b1, 12'h010, 32'hff);
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        apb(1'b1, `RXBE_OFS_CTRL, 32'h72);
        apb(1'b0, `RXBE_OFS_CTRL, 32'h0);
        `CHK("ctrl_rw", 32'h72, rd)
        $display("TEST registers done");
        for (int fs = 0; fs < 2; fs++)
        begin
            apb(1'b1, `RXBE_OFS_CTRL, 32'(fs << `RXBE_CTRL_FRAMSEL));
            for (int i = 0; i < 24; i++)
            begin
                r = (i % 4 == 0) ? fr[(i / 4) % 4] : 10'($random(seed));
                src.send(r, 8'h00, 3'h0, 1 + i % 3);
                `CHK("bypass", exp_byp(r, fs[0]), {rx_data, rx_st})
            end
        end
        $display("TEST bypass done");
        apb(1'b1, `RXBE_OFS_CTRL, 32'h02);
        for (int i = 0; i < 16; i++)
        begin
            d = 8'($random(seed));
            r = 10'($random(seed));
            src.send(r, d, r[2:0], 1 + i % 3);
            `CHK("decoded", {d, r[2:0]}, {rx_data, rx_st})
        end
        $display("TEST decoded done");
        apb(1'b1, `RXBE_OFS_CTRL, 32'h80);
        p = rx_ph;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            `CHK("phase", ~p, rx_ph)
            p = rx_ph;
        end
        apb(1'b1, `RXBE_OFS_CTRL, 32'h00);
        @(posedge clk);
        `CHK("phase_full", 1'b1, rx_ph)
        $display("TEST clock phase done");
        apb(1'b1, `RXBE_OFS_CTRL, 32'h02);
        src.sync_word(4);
        apb(1'b1, `RXBE_OFS_CTRL, 32'h03);
        for (int i = 0; i < 3; i++)
        begin
            src.send(10'h0, 8'h5a, 3'h0, 1);
            `CHK("st_wait", `RXBE_ST_WAIT, rx_st)
        end
        src.send(10'h0, `RXBE_START_CHAR, 3'h0, 0);
        for (int i = 0; i < 40; i++)
            src.send(10'h0, 8'ha5, 3'h0, i / 39);
        `CHK("st_abort", `RXBE_ST_WAIT, rx_st)
        src.send(10'h0, `RXBE_START_CHAR, 3'h0, 1);
        pll_ok <= 1'b0;
        @(posedge clk);
        pll_ok <= 1'b1;
        src.send(10'h0, 8'ha5, 3'h0, 1);
        `CHK("st_unlock", `RXBE_ST_WAIT, rx_st)
        src.send(10'h0, `RXBE_START_CHAR, 3'h0, 0);
        lf = `RXBE_LFSR_SEED;
        for (int i = 1; i < 511; i++)
        begin
            src.send(10'h0, lf[7:0], 3'h0, (i == 1 || i == 510) ? 1 : 0);
            lf = lfsr_step(lf);
            if (i == 1)
                `CHK("st_match", `RXBE_ST_MATCH, rx_st)
        end
        `CHK("st_loop", `RXBE_ST_LOOP_A, rx_st)
        do_reset();
        $display("TEST self test done");
        apb(1'b1, `RXBE_OFS_CTRL, 32'h06);
        src.sync_word(16);
        collect <= 1'b1;
        for (int i = 1; i < 40; i++)
        begin
            if (i % 4 == 0)
                src.sync_word(1);
            else
            begin
                exp_q.push_back(8'(8'h20 + i));
                src.send(10'h0, 8'(8'h20 + i), 3'h0, 0);
            end
        end
        src.sync_word(12);
        collect <= 1'b0;
        @(posedge clk);
        k = 0;
        while (k < got_q.size() && got_q[k] !== 8'h21)
            k++;
        foreach (exp_q[j])
            `CHK("ebuf", exp_q[j], (k + j < got_q.size()) ? got_q[k + j] : 8'hxx)
        $display("TEST elastic done");
        stop_test();
    end
endmodule : rxbe_top_tb
`default_nettype wire
